//--- logic/lbcfg_pkg.sv
// package: register map, field layout, reset values and types of lane/ddc_gain_config
package lbcfg_pkg;
  // printed offsets are not multiples of four: they are indices, byte = 4*idx
  localparam logic [11:0] IDX_EXTRA_LANE = 12'h20b;
  localparam logic [11:0] IDX_SYNC_HDR = 12'h20f;
  localparam logic [11:0] IDX_DDC_GAIN = 12'h210;
  localparam logic [11:0] IDX_THR_I = 12'h211;
  localparam logic [11:0] IDX_THR_Q = 12'h212;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h300;
  localparam logic [11:0] IDX_IRQ_ENABLE = 12'h301;
  localparam logic [11:0] IDX_IRQ_CLEAR = 12'h302;
  localparam logic [11:0] IDX_LANE_STATUS = 12'h303;
  localparam logic [7:0] RST_EXTRA_LANE = 8'h00;
  localparam logic [7:0] RST_SYNC_HDR = 8'h00;
  localparam logic [7:0] RST_DDC_GAIN = 8'h00;
  localparam logic [7:0] RST_THR_I = 8'hf2;
  localparam logic [7:0] RST_THR_Q = 8'hab;
  localparam int SER_ON_BIT = 0;
  localparam int LANE_LSB = 1;
  localparam int LANE_MSB = 7;
  localparam int GAIN_BIT = 0;
  localparam int SH_LSB = 0;
  localparam int SH_MSB = 1;
  localparam logic [1:0] SH_CRC12 = 2'h0;
  localparam logic [1:0] SH_FEC = 2'h2;
  localparam logic [2:0] TP_NONE = 3'h0;
  localparam logic [2:0] TP_RAMP = 3'h4;
  localparam logic [2:0] TP_ALT = 3'h5;
  // irq status bit positions
  localparam int EV_OVR_I = 0;
  localparam int EV_OVR_Q = 1;
  localparam int EV_CFG_LIVE = 2;
  localparam int IRQ_W = 3;

  typedef enum logic [1:0] {
    LBCFG_SYNC_CRC12 = 2'h1,
    LBCFG_SYNC_FEC = 2'h2
  } lbcfg_sync_t;

  typedef struct packed {
    logic [7:0] lane_clk_on;
    logic [7:0] ser_clk_on;
    logic [7:0] ramp_force;
  } lbcfg_lane_t;
endpackage : lbcfg_pkg

//--- logic/lbcfg_top.sv
// top: apb register slice, extra-lane control, sync mode, ddc gain, over-range
`timescale 1ns/1ps
//
// Contract
// - bits 7:1 enable link-b lane clocks
// - extra enable honoured despite link format
// - ser bit 0: clocks only, serializers off
// - ser bit 1: serializers and clocks on
// - extra lanes follow format and test pattern
// - extra-only lane ramps when pattern 0/5
// - channel powerdown keeps extra lanes off
// - serializer n clocked only if lower enabled
// - sync field: 0 crc12, 2 fec
// - sync select applies only in 64b/66b
// - no command channel, fields sent zero
// - gain bit doubles ddc filter output
// - i sample flag at threshold i
// - level is threshold over 256 fullscale
// - q sample flag at threshold q
module lbcfg_top #(
  parameter int SAMPLE_W = 16,
  parameter int LANES = 8
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [13:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic link_enable_in,
  input wire logic link_format_is_66b_in,
  input wire logic [LANES-1:0] link_format_lanes_in,
  input wire logic [2:0] link_test_pattern_select_in,
  input wire logic channel_powerdown_in,
  input wire logic sample_valid_in,
  input wire logic signed [SAMPLE_W-1:0] ddc_i_in,
  input wire logic signed [SAMPLE_W-1:0] ddc_q_in,
  output logic [LANES-1:0] lane_clk_on_out,
  output logic [LANES-1:0] serializer_clk_on_out,
  output logic [LANES-1:0] lane_ramp_force_out,
  output logic [2:0] lane_test_pattern_out,
  output logic sync_hdr_apply_out,
  output logic [1:0] sync_hdr_mode_out,
  output logic [7:0] sync_cmd_field_out,
  output logic signed [SAMPLE_W:0] ddc_i_out,
  output logic signed [SAMPLE_W:0] ddc_q_out,
  output logic ddc_ctrl_bit0_out,
  output logic ddc_ctrl_bit1_out,
  output logic ddc_valid_out,
  output logic irq_out
);
  logic [7:0] extra_lane_ff;
  logic [7:0] sync_hdr_ff;
  logic [7:0] ddc_gain_ff;
  logic [7:0] thr_i_ff;
  logic [7:0] thr_q_ff;
  logic [lbcfg_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [lbcfg_pkg::IRQ_W-1:0] irq_en_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  lbcfg_pkg::lbcfg_lane_t lane_ff;
  lbcfg_pkg::lbcfg_lane_t nxt_lane;
  logic [1:0] sync_mode_ff;
  logic sync_apply_ff;
  logic [2:0] tp_ff;
  logic signed [SAMPLE_W:0] i_ff;
  logic signed [SAMPLE_W:0] q_ff;
  logic ovr_i_ff;
  logic ovr_q_ff;
  logic valid_ff;

  logic [11:0] idx;
  logic wr_acc;
  logic rd_acc;
  logic addr_hit;
  logic cfg_hit;
  logic [31:0] nxt_rdata;
  localparam int IRQ_W_L = lbcfg_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] irq_set;
  logic [IRQ_W_L-1:0] irq_clr;
  logic nxt_ovr_i;
  logic nxt_ovr_q;

  // zero-wait slave: every access completes in its first access cycle
  assign idx = paddr_in[13:2];
  assign wr_acc = psel_in & penable_in & pwrite_in;
  assign rd_acc = psel_in & penable_in & ~pwrite_in;
  assign pready_out = 1'b1;
  assign prdata_out = prdata_ff;
  assign pslverr_out = pslverr_ff;

  always_comb begin
    addr_hit = 1'b1;
    nxt_rdata = 32'h0000_0000;
    case (idx)
      lbcfg_pkg::IDX_EXTRA_LANE: nxt_rdata = {24'h000000, extra_lane_ff};
      lbcfg_pkg::IDX_SYNC_HDR: nxt_rdata = {24'h000000, sync_hdr_ff};
      lbcfg_pkg::IDX_DDC_GAIN: nxt_rdata = {24'h000000, ddc_gain_ff};
      lbcfg_pkg::IDX_THR_I: nxt_rdata = {24'h000000, thr_i_ff};
      lbcfg_pkg::IDX_THR_Q: nxt_rdata = {24'h000000, thr_q_ff};
      lbcfg_pkg::IDX_IRQ_STATUS: nxt_rdata = {29'h0, irq_stat_ff};
      lbcfg_pkg::IDX_IRQ_ENABLE: nxt_rdata = {29'h0, irq_en_ff};
      lbcfg_pkg::IDX_IRQ_CLEAR: nxt_rdata = 32'h0000_0000;
      lbcfg_pkg::IDX_LANE_STATUS:
        nxt_rdata = {8'h00, lane_ff.ramp_force, lane_ff.ser_clk_on,
                     lane_ff.lane_clk_on};
      default: addr_hit = 1'b0;
    endcase
  end

  // read data is registered, so a read returns one cycle after setup
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      if (psel_in & ~penable_in) begin
        prdata_ff <= pwrite_in ? 32'h0000_0000 : nxt_rdata;
        pslverr_ff <= ~addr_hit;
      end else if (~psel_in) begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  assign cfg_hit = wr_acc & addr_hit & pstrb_in[0];

  // config writes; the lane and sync fields are not locked while the link
  // runs, software must hold link enable low itself
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      extra_lane_ff <= lbcfg_pkg::RST_EXTRA_LANE;
      sync_hdr_ff <= lbcfg_pkg::RST_SYNC_HDR;
      ddc_gain_ff <= lbcfg_pkg::RST_DDC_GAIN;
      thr_i_ff <= lbcfg_pkg::RST_THR_I;
      thr_q_ff <= lbcfg_pkg::RST_THR_Q;
      irq_en_ff <= '0;
    end else if (cfg_hit) begin
      case (idx)
        lbcfg_pkg::IDX_EXTRA_LANE: extra_lane_ff <= pwdata_in[7:0];
        lbcfg_pkg::IDX_SYNC_HDR: sync_hdr_ff <= pwdata_in[7:0];
        lbcfg_pkg::IDX_DDC_GAIN: ddc_gain_ff <= pwdata_in[7:0];
        lbcfg_pkg::IDX_THR_I: thr_i_ff <= pwdata_in[7:0];
        lbcfg_pkg::IDX_THR_Q: thr_q_ff <= pwdata_in[7:0];
        lbcfg_pkg::IDX_IRQ_ENABLE: irq_en_ff <= pwdata_in[IRQ_W_L-1:0];
        default: ;
      endcase
    end
  end

  // lane control: mask adds lanes beyond the format, serializer chain gated
  always_comb begin
    logic [LANES-1:0] want;
    logic [LANES-1:0] extra;
    logic chain;
    want = '0;
    extra = '0;
    chain = 1'b1;
    nxt_lane = '0;
    for (int n = 0; n < LANES; n++) begin
      extra[n] = (n >= lbcfg_pkg::LANE_LSB && n <= lbcfg_pkg::LANE_MSB) ?
                 extra_lane_ff[n] : 1'b0;
      want[n] = link_format_lanes_in[n] | extra[n];
    end
    if (!channel_powerdown_in) begin
      for (int n = 0; n < LANES; n++) begin
        nxt_lane.lane_clk_on[n] = want[n];
        // format lanes serialize while the chain holds; extra ones also need ser bit
        chain = chain & want[n];
        nxt_lane.ser_clk_on[n] = chain & (link_format_lanes_in[n] |
          extra_lane_ff[lbcfg_pkg::SER_ON_BIT]);
        nxt_lane.ramp_force[n] = extra[n] & ~link_format_lanes_in[n] &
          ((link_test_pattern_select_in == lbcfg_pkg::TP_NONE) |
           (link_test_pattern_select_in == lbcfg_pkg::TP_ALT));
      end
    end
  end

  // ser chain: once a lower lane is off every higher serializer is cut
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lane_ff <= '0;
      tp_ff <= lbcfg_pkg::TP_NONE;
    end else begin
      lane_ff <= nxt_lane;
      tp_ff <= link_test_pattern_select_in;
    end
  end

  // sync header mode only meaningful on a 64b/66b format
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync_mode_ff <= lbcfg_pkg::SH_CRC12;
      sync_apply_ff <= 1'b0;
    end else begin
      sync_mode_ff <= sync_hdr_ff[lbcfg_pkg::SH_MSB:lbcfg_pkg::SH_LSB];
      sync_apply_ff <= link_format_is_66b_in & link_enable_in &
        ((sync_hdr_ff[lbcfg_pkg::SH_MSB:lbcfg_pkg::SH_LSB] ==
          lbcfg_pkg::SH_CRC12) |
         (sync_hdr_ff[lbcfg_pkg::SH_MSB:lbcfg_pkg::SH_LSB] ==
          lbcfg_pkg::SH_FEC));
    end
  end

  // magnitude top bits; threshold/256 of full scale sets the level
  function automatic logic [7:0] mag_top(input logic signed [SAMPLE_W-1:0] s);
    logic [SAMPLE_W-1:0] m;
    m = s[SAMPLE_W-1] ? SAMPLE_W'(-s) : SAMPLE_W'(s);
    // most negative code saturates instead of wrapping to zero
    if (m[SAMPLE_W-1]) begin
      m = {1'b0, {(SAMPLE_W-1){1'b1}}};
    end
    mag_top = m[SAMPLE_W-2 -: 8];
  endfunction : mag_top

  assign nxt_ovr_i = sample_valid_in &
    (mag_top(ddc_i_in) >= thr_i_ff);
  assign nxt_ovr_q = sample_valid_in &
    (mag_top(ddc_q_in) >= thr_q_ff);

  // gain applied on a one-bit-wider output, so doubling never wraps here
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      i_ff <= '0;
      q_ff <= '0;
      ovr_i_ff <= 1'b0;
      ovr_q_ff <= 1'b0;
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= sample_valid_in;
      ovr_i_ff <= nxt_ovr_i;
      ovr_q_ff <= nxt_ovr_q;
      if (ddc_gain_ff[lbcfg_pkg::GAIN_BIT]) begin
        i_ff <= {ddc_i_in, 1'b0};
        q_ff <= {ddc_q_in, 1'b0};
      end else begin
        i_ff <= {ddc_i_in[SAMPLE_W-1], ddc_i_in};
        q_ff <= {ddc_q_in[SAMPLE_W-1], ddc_q_in};
      end
    end
  end

  // interrupts: set beats clear in the same cycle
  assign irq_set = {link_enable_in & cfg_hit &
                    ((idx == lbcfg_pkg::IDX_EXTRA_LANE) |
                     (idx == lbcfg_pkg::IDX_SYNC_HDR)),
                    nxt_ovr_q, nxt_ovr_i};
  assign irq_clr = (cfg_hit && idx == lbcfg_pkg::IDX_IRQ_CLEAR) ?
                   pwdata_in[IRQ_W_L-1:0] : '0;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
    end
  end

  assign irq_out = |(irq_stat_ff & irq_en_ff);
  assign lane_clk_on_out = lane_ff.lane_clk_on;
  assign serializer_clk_on_out = lane_ff.ser_clk_on;
  assign lane_ramp_force_out = lane_ff.ramp_force;
  // forced lanes use the ramp; the downstream mux picks per lane
  assign lane_test_pattern_out = tp_ff;
  assign sync_hdr_apply_out = sync_apply_ff;
  assign sync_hdr_mode_out = sync_mode_ff;
  assign sync_cmd_field_out = 8'h00;
  assign ddc_i_out = i_ff;
  assign ddc_q_out = q_ff;
  assign ddc_ctrl_bit0_out = ovr_i_ff;
  assign ddc_ctrl_bit1_out = ovr_q_ff;
  assign ddc_valid_out = valid_ff;
endmodule : lbcfg_top

//--- tb/lbcfg_top_asserts.sv
// checker: port-level assertions for the lane and ddc config slice
`timescale 1ns/1ps
module lbcfg_top_asserts #(
  parameter int SAMPLE_W = 16,
  parameter int LANES = 8
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic pready_out,
  input wire logic link_enable_in,
  input wire logic link_format_is_66b_in,
  input wire logic [LANES-1:0] link_format_lanes_in,
  input wire logic [2:0] link_test_pattern_select_in,
  input wire logic channel_powerdown_in,
  input wire logic sample_valid_in,
  input wire logic signed [SAMPLE_W-1:0] ddc_i_in,
  input wire logic [LANES-1:0] lane_clk_on_out,
  input wire logic [LANES-1:0] serializer_clk_on_out,
  input wire logic [LANES-1:0] lane_ramp_force_out,
  input wire logic sync_hdr_apply_out,
  input wire logic [7:0] sync_cmd_field_out,
  input wire logic signed [SAMPLE_W:0] ddc_i_out,
  input wire logic ddc_valid_out
);
  logic [LANES-1:0] chain;
  // a serializer may run only on top of an unbroken run of lower lanes
  always_comb begin
    chain[0] = lane_clk_on_out[0];
    for (int n = 1; n < LANES; n++) begin
      chain[n] = chain[n-1] & lane_clk_on_out[n];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // outputs still hold reset values at the first edge after release
  sequence s_live; $past(reset_n_in); endsequence
  sequence s_sample; s_live ##0 ddc_valid_out; endsequence
  property p_pready; pready_out == 1'b1; endproperty
  property p_cmd_zero; sync_cmd_field_out == 8'h00; endproperty
  property p_pd_off; s_live ##0 $past(channel_powerdown_in) |->
    (lane_clk_on_out | serializer_clk_on_out | lane_ramp_force_out) == '0;
  endproperty
  property p_fmt_lanes; s_live ##0 !$past(channel_powerdown_in) |->
    (lane_clk_on_out & $past(link_format_lanes_in)) ==
    $past(link_format_lanes_in); endproperty
  property p_lane0; s_live |-> lane_clk_on_out[0] ==
    $past(!channel_powerdown_in && link_format_lanes_in[0]); endproperty
  property p_ser_chain; (serializer_clk_on_out & ~chain) == '0; endproperty
  property p_ramp; s_live ##0 (lane_ramp_force_out != '0) |->
    $past(link_test_pattern_select_in == lbcfg_pkg::TP_NONE ||
    link_test_pattern_select_in == lbcfg_pkg::TP_ALT) &&
    (lane_ramp_force_out & $past(link_format_lanes_in)) == '0; endproperty
  property p_sync; s_live ##0 sync_hdr_apply_out |->
    $past(link_format_is_66b_in && link_enable_in); endproperty
  property p_valid; s_live |-> ddc_valid_out == $past(sample_valid_in);
  endproperty
  property p_gain; s_sample |->
    ddc_i_out == {$past(ddc_i_in[SAMPLE_W-1]), $past(ddc_i_in)} ||
    ddc_i_out == {$past(ddc_i_in), 1'b0}; endproperty
  a_pready: assert property (p_pready) else $error("pready low");
  a_cmd_zero: assert property (p_cmd_zero) else $error("cmd nonzero");
  a_pd_off: assert property (p_pd_off) else $error("lane on in pd");
  a_fmt_lanes: assert property (p_fmt_lanes) else $error("fmt lane off");
  a_lane0: assert property (p_lane0) else $error("lane0 wrong");
  a_ser_chain: assert property (p_ser_chain) else $error("ser gap");
  a_ramp: assert property (p_ramp) else $error("bad ramp");
  a_sync: assert property (p_sync) else $error("sync applied");
  a_valid: assert property (p_valid) else $error("valid lost");
  a_gain: assert property (p_gain) else $error("gain wrong");
endmodule : lbcfg_top_asserts

bind lbcfg_top lbcfg_top_asserts #(.SAMPLE_W(SAMPLE_W), .LANES(LANES)) u_chk (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .pready_out(pready_out),
  .link_enable_in(link_enable_in),
  .link_format_is_66b_in(link_format_is_66b_in),
  .link_format_lanes_in(link_format_lanes_in),
  .link_test_pattern_select_in(link_test_pattern_select_in),
  .channel_powerdown_in(channel_powerdown_in),
  .sample_valid_in(sample_valid_in), .ddc_i_in(ddc_i_in),
  .lane_clk_on_out(lane_clk_on_out),
  .serializer_clk_on_out(serializer_clk_on_out),
  .lane_ramp_force_out(lane_ramp_force_out),
  .sync_hdr_apply_out(sync_hdr_apply_out),
  .sync_cmd_field_out(sync_cmd_field_out), .ddc_i_out(ddc_i_out),
  .ddc_valid_out(ddc_valid_out));

//--- tb/lbcfg_top_test.sv
// testbench: apb registers, lane control, sync mode, ddc gain and flags
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module lbcfg_top_test;
  logic clk_in, reset_n_in, psel, penable, pwrite, pready, pslverr;
  logic err, link_en, is66, pd, svalid, apply, f0, f1, dv, irq;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [3:0] pstrb;
  logic [7:0] fmt, clk_on, ser_on, ramp, cmd, m, f, ti, tq, g;
  logic [2:0] tp, tp_out;
  logic [1:0] sh_mode;
  logic signed [15:0] si, sq, s, s2;
  logic signed [16:0] io, qo;
  logic [23:0] e;
  logic [11:0] idx_tab [5];
  logic [7:0] rst_tab [5];
  int errors, checks_done, i, seed;
  lbcfg_top DUT (.clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .link_enable_in(link_en),
    .link_format_is_66b_in(is66), .link_format_lanes_in(fmt),
    .link_test_pattern_select_in(tp), .channel_powerdown_in(pd),
    .sample_valid_in(svalid), .ddc_i_in(si), .ddc_q_in(sq),
    .lane_clk_on_out(clk_on), .serializer_clk_on_out(ser_on),
    .lane_ramp_force_out(ramp), .lane_test_pattern_out(tp_out),
    .sync_hdr_apply_out(apply), .sync_hdr_mode_out(sh_mode),
    .sync_cmd_field_out(cmd), .ddc_i_out(io), .ddc_q_out(qo),
    .ddc_ctrl_bit0_out(f0), .ddc_ctrl_bit1_out(f1), .ddc_valid_out(dv),
    .irq_out(irq));
  always #20 clk_in = ~clk_in;
  task complete_run;
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task apb(input logic w, input logic [11:0] x, input logic [31:0] d,
           input logic [3:0] st);
    int n;
    @(posedge clk_in);
    psel <= 1; pwrite <= w; paddr <= {x, 2'b00}; pwdata <= d; pstrb <= st;
    @(posedge clk_in);
    penable <= 1;
    // prdata and pslverr were loaded at the setup edge and stand here
    for (n = 0; n < 16; n++) begin
      @(posedge clk_in);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin errors++; complete_run(); end
    rd = prdata; err = pslverr; psel <= 0; penable <= 0;
  endtask : apb
  function automatic logic [23:0] lane_exp(logic [7:0] mk, logic [7:0] fm,
                                          logic [2:0] t, logic p);
    logic [7:0] w, c, sr, r;
    logic all;
    all = 1'b1;
    for (int n = 0; n < 8; n++) begin
      w[n] = fm[n] | (n >= 1 && mk[n]);
      all = all & w[n];
      c[n] = !p && w[n];
      sr[n] = !p && all && (fm[n] || mk[0]);
      r[n] = !p && n >= 1 && mk[n] && !fm[n] && (t == 3'h0 || t == 3'h5);
    end
    return {r, sr, c};
  endfunction : lane_exp
  function automatic logic flag(logic signed [15:0] x, logic [7:0] t);
    logic [15:0] mg;
    mg = x[15] ? -x : x;
    if (x == 16'h8000) mg = 16'h7fff;
    return mg[14:7] >= t;
  endfunction : flag
  initial begin
    clk_in = 0; reset_n_in = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; pstrb = 0; link_en = 0; is66 = 0; pd = 0;
    svalid = 0; fmt = 0; tp = 0; si = 0; sq = 0; errors = 0; checks_done = 0;
    idx_tab = '{lbcfg_pkg::IDX_EXTRA_LANE, lbcfg_pkg::IDX_SYNC_HDR,
      lbcfg_pkg::IDX_DDC_GAIN, lbcfg_pkg::IDX_THR_I, lbcfg_pkg::IDX_THR_Q};
    rst_tab = '{8'h00, 8'h00, 8'h00, 8'hf2, 8'hab};
    seed = $urandom(78);
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1;
    for (i = 0; i < 5; i++) begin
      apb(0, idx_tab[i], 0, 4'hf);
      `CHK(rd, {24'h0, rst_tab[i]})
    end
    apb(0, 12'h100, 0, 4'hf);
    `CHK({err, rd}, {1'b1, 32'h0})
    for (i = 0; i < 5; i++) begin
      v = $urandom;
      apb(1, idx_tab[i], v, 4'hf);
      apb(1, idx_tab[i], ~v, 4'h0);
      apb(0, idx_tab[i], 0, 4'hf);
      `CHK(rd, {24'h0, v[7:0]})
    end
    for (i = 0; i < 24; i++) begin
      m = (i < 2) ? 8'hfe | i[0] : $urandom;
      f = (i < 4) ? 8'h01 : $urandom;
      apb(1, lbcfg_pkg::IDX_EXTRA_LANE, {24'h0, m}, 4'hf);
      fmt <= f; tp <= i[2:0]; pd <= (i % 7 == 6);
      repeat (2) @(posedge clk_in); #1;
      e = lane_exp(m, f, i[2:0], i % 7 == 6);
      `CHK(clk_on, e[7:0])
      `CHK(ser_on, e[15:8])
      `CHK(ramp, e[23:16])
      `CHK(tp_out, i[2:0])
      apb(0, lbcfg_pkg::IDX_LANE_STATUS, 0, 4'hf);
      `CHK(rd, {8'h00, e})
    end
    apb(1, lbcfg_pkg::IDX_IRQ_ENABLE, 32'h4, 4'hf);
    for (i = 0; i < 8; i++) begin
      @(posedge clk_in);
      link_en <= 0; is66 <= i[2];
      apb(1, lbcfg_pkg::IDX_SYNC_HDR, i[1:0], 4'hf);
      link_en <= 1;
      repeat (2) @(posedge clk_in); #1;
      `CHK(apply, i[2] && !i[0])
      `CHK(sh_mode, i[1:0])
      `CHK(cmd, 8'h00)
    end
    apb(1, lbcfg_pkg::IDX_EXTRA_LANE, 0, 4'hf);
    @(negedge clk_in);
    `CHK(irq, 1'b1)
    apb(1, lbcfg_pkg::IDX_IRQ_ENABLE, 0, 4'hf);
    @(negedge clk_in);
    `CHK(irq, 1'b0)
    apb(1, lbcfg_pkg::IDX_IRQ_CLEAR, 32'h4, 4'hf);
    apb(1, lbcfg_pkg::IDX_IRQ_ENABLE, 32'h4, 4'hf);
    link_en <= 0; svalid <= 1;
    @(negedge clk_in);
    `CHK(irq, 1'b0)
    for (i = 0; i < 40; i++) begin
      if (i % 10 == 0) begin
        ti = $urandom; tq = $urandom; g = $urandom;
        apb(1, lbcfg_pkg::IDX_THR_I, ti, 4'hf);
        apb(1, lbcfg_pkg::IDX_THR_Q, tq, 4'hf);
        apb(1, lbcfg_pkg::IDX_DDC_GAIN, g, 4'hf);
      end
      s = (i % 10 == 1) ? 16'h8000 : (i % 10 == 2) ? {1'b0, ti, 7'h0} :
          (i % 10 == 3) ? {1'b0, ti, 7'h0} - 16'h1 : $urandom;
      s2 = (i % 10 == 4) ? -{1'b0, tq, 7'h0} : $urandom;
      @(posedge clk_in);
      si <= s; sq <= s2;
      @(posedge clk_in); #1;
      `CHK(io, g[0] ? {s, 1'b0} : {s[15], s})
      `CHK(qo, g[0] ? {s2, 1'b0} : {s2[15], s2})
      `CHK({dv, f0}, {1'b1, flag(s, ti)})
      `CHK(f1, flag(s2, tq))
    end
    // steps 2 and 4 of every ten always reach their threshold
    apb(0, lbcfg_pkg::IDX_IRQ_STATUS, 0, 4'hf);
    `CHK(rd, 32'h0000_0003)
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    complete_run();
  end
endmodule : lbcfg_top_test
